// ==== hw/lsp_map.svh ====
`ifndef LSP_MAP_SVH
`define LSP_MAP_SVH
// clock rate in kHz, so ms * kHz gives cycles
`define LSP_CLK_KHZ      25000
// pattern times in ms, no printed figures exist
`define LSP_FLASH_MS     20
`define LSP_SLOW_HALF_MS 500
`define LSP_FAST_HALF_MS 125
`define LSP_NUM_CH       5
// colour elements: power has two, each channel two
`define LSP_PWR_ELEMS    2
`define LSP_CH_ELEMS     2
`define LSP_RUN_FIRST    0
`endif

// ==== hw/lsp_pkg.sv ====
package lsp_pkg;
   typedef enum logic [3:0] {
      LSP_PWR_OFF       = 4'h0,
      LSP_PWR_GREEN     = 4'h1,
      LSP_PWR_YELLOW    = 4'h2,
      LSP_PWR_SLOW_G    = 4'h3,
      LSP_PWR_FAST_G    = 4'h4,
      LSP_PWR_SLOW_Y    = 4'h5,
      LSP_PWR_SLOW_WAVE = 4'h6,
      LSP_PWR_FAST_WAVE = 4'h7,
      LSP_PWR_RUN       = 4'h8
   } lsp_pwr_pat_e;

   typedef enum logic [3:0] {
      LSP_TRF_CHAN      = 4'h0,
      LSP_TRF_OFF       = 4'h1,
      LSP_TRF_SLOW_Y    = 4'h2,
      LSP_TRF_FAST_Y    = 4'h3,
      LSP_TRF_SLOW_R    = 4'h4,
      LSP_TRF_FAST_R    = 4'h5,
      LSP_TRF_SLOW_WAVE = 4'h6,
      LSP_TRF_FAST_WAVE = 4'h7,
      LSP_TRF_RUN       = 4'h8
   } lsp_trf_pat_e;
endpackage

// ==== hw/lsp_tim_if.sv ====
`timescale 1ns/10ps
interface lsp_tim_if;
   logic slow_ph;
   logic fast_ph;
   modport src (output slow_ph, output fast_ph);
   modport snk (input slow_ph, input fast_ph);
endinterface

// ==== hw/lsp_chan_status.sv ====
`timescale 1ns/10ps
`include "lsp_map.svh"
module lsp_chan_status #(
   parameter int FLASH_CYC = `LSP_FLASH_MS * `LSP_CLK_KHZ
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   // shared blink phases
   lsp_tim_if.snk    tim,
   // channel events
   input  wire logic msg_evt_i,
   input  wire logic err_frame_i,
   input  wire logic err_passive_i,
   input  wire logic overrun_i,
   input  wire logic bus_off_i,
   // channel colours
   output logic      yellow_o,
   output logic      red_o
);
   import lsp_pkg::*;
   localparam int FW = $clog2(FLASH_CYC + 1);

   if (FLASH_CYC < 1) begin : g_bad
      $error("flash length must be at least one cycle");
   end

   typedef struct packed {
      logic [FW-1:0] yel_cnt;
      logic [FW-1:0] red_cnt;
      logic          ovr_lat;
   } lsp_chan_s;

   lsp_chan_s st;
   lsp_chan_s next_st;

   always_comb begin
      next_st = st;
      // retrigger keeps back-to-back flashes lit
      if (msg_evt_i) begin
         next_st.yel_cnt = FW'(FLASH_CYC);
      end else if (st.yel_cnt != '0) begin
         next_st.yel_cnt = st.yel_cnt - 1'b1;
      end
      if (err_frame_i) begin
         next_st.red_cnt = FW'(FLASH_CYC);
      end else if (st.red_cnt != '0) begin
         next_st.red_cnt = st.red_cnt - 1'b1;
      end
      // overrun set wins over a bus-off in the same cycle
      if (bus_off_i) begin
         next_st.ovr_lat = 1'b0;
      end
      if (overrun_i) begin
         next_st.ovr_lat = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // red beats yellow: one element of a dual LED at a time
   always_comb begin
      yellow_o = 1'b0;
      red_o    = 1'b0;
      if (st.ovr_lat) begin
         red_o = 1'b1;
      end else if (err_passive_i) begin
         red_o = tim.fast_ph;
      end else if (st.red_cnt != '0) begin
         red_o = 1'b1;
      end else begin
         yellow_o = (st.yel_cnt != '0);
      end
   end

   logic [FW:0] h_since;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         h_since <= '0;
      end else if (msg_evt_i) begin
         h_since <= (FW+1)'(1);
      end else if (h_since != '0 && h_since <= (FW+1)'(FLASH_CYC)) begin
         h_since <= h_since + 1'b1;
      end
   end

   property p_flash_ends;
      @(posedge clk_i) disable iff (sys_rst_i)
      h_since == (FW+1)'(FLASH_CYC + 1) |-> !yellow_o;
   endproperty
   a_flash_ends: assert property (p_flash_ends)
      else $error("yellow flash outlasts its length");

   property p_overrun_red;
      @(posedge clk_i) disable iff (sys_rst_i)
      overrun_i |=> red_o && !yellow_o;
   endproperty
   a_overrun_red: assert property (p_overrun_red)
      else $error("overrun did not give steady red");

   property p_passive_fast;
      @(posedge clk_i) disable iff (sys_rst_i)
      err_passive_i && !st.ovr_lat |-> red_o == tim.fast_ph;
   endproperty
   a_passive_fast: assert property (p_passive_fast)
      else $error("error passive not fast blink red");

   c_flash: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      msg_evt_i ##1 yellow_o);
endmodule

// ==== hw/led_status_pattern_encoder.sv ====
// Behaviour
// - separate power and per-channel traffic indicators
// - device errors drive all red together
// - flash is one short pulse, retriggerable
// - slow blink, equal on and off
// - fast blink, equal halves, faster than slow
// - slow waver alternates colours at slow rate
// - fast waver alternates colours at fast rate
// - running lights one element in order
// - configured host mode: steady green power
// - host problem states map to fixed pairs
// - low supply raises power-problem pattern
// - idle off, yellow message flash, red error
// - error passive gives fast blink red
// - overrun red latched until bus-off
// - firmware update: all traffic fast yellow
// - tool exchange: running on every indicator
// - disk activity: green, traffic fast yellow
// - logger hardware and battery faults waver
// - storage fault: yellow, slow red traffic
// - bad configuration: yellow, fast red traffic
// - armed green, active fast, stopped slow
// - logger traffic uses per-channel status
// - user program override; load fail shows
`timescale 1ns/10ps
`include "lsp_map.svh"
module led_status_pattern_encoder #(
   parameter int NUM_CH        = `LSP_NUM_CH,
   parameter int FLASH_CYC     = `LSP_FLASH_MS * `LSP_CLK_KHZ,
   parameter int SLOW_HALF_CYC = `LSP_SLOW_HALF_MS * `LSP_CLK_KHZ,
   parameter int FAST_HALF_CYC = `LSP_FAST_HALF_MS * `LSP_CLK_KHZ
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   // host-interface side state
   input  wire logic              host_mode_i,
   input  wire logic              usb_configured_i,
   input  wire logic              fw_cfg_err_i,
   input  wire logic              supply_low_i,
   input  wire logic              fw_update_i,
   input  wire logic              tool_comm_i,
   input  wire logic              disk_busy_i,
   // logger side state
   input  wire logic              hw_err_i,
   input  wire logic              battery_fault_i,
   input  wire logic              disk_err_i,
   input  wire logic              cfg_missing_i,
   input  wire logic              prog_load_fail_i,
   input  wire logic              log_armed_i,
   input  wire logic              log_active_i,
   input  wire logic              log_trig_stop_i,
   // per-channel bus events
   input  wire logic [NUM_CH-1:0] msg_evt_i,
   input  wire logic [NUM_CH-1:0] err_frame_i,
   input  wire logic [NUM_CH-1:0] err_passive_i,
   input  wire logic [NUM_CH-1:0] overrun_i,
   input  wire logic [NUM_CH-1:0] bus_off_i,
   // user program override, bit 0 is power
   input  wire logic [NUM_CH:0]   prog_ovr_en_i,
   input  wire logic [1:0]        pwr_ovr_i,
   input  wire logic [2*NUM_CH-1:0] trf_ovr_i,
   // indicator drives
   output logic                   pwr_green_o,
   output logic                   pwr_yellow_o,
   output logic [NUM_CH-1:0]      trf_yellow_o,
   output logic [NUM_CH-1:0]      trf_red_o
);
   import lsp_pkg::*;

   localparam int SW  = $clog2(SLOW_HALF_CYC + 1);
   localparam int FW  = $clog2(FAST_HALF_CYC + 1);
   localparam int NEL = `LSP_PWR_ELEMS + `LSP_CH_ELEMS * NUM_CH;
   localparam int RW  = $clog2(NEL);

   // fast must be strictly faster than slow
   if (FAST_HALF_CYC < 1 || FAST_HALF_CYC >= SLOW_HALF_CYC ||
       FLASH_CYC < 1 || NUM_CH < 1) begin : g_bad
      $error("pattern timing or channel count unusable");
   end

   typedef struct packed {
      logic [SW-1:0]     slow_cnt;
      logic [FW-1:0]     fast_cnt;
      logic              slow_ph;
      logic              fast_ph;
      logic [RW-1:0]     run_idx;
      logic              pwr_g;
      logic              pwr_y;
      logic [NUM_CH-1:0] trf_y;
      logic [NUM_CH-1:0] trf_r;
   } lsp_top_s;

   lsp_top_s     st;
   lsp_top_s     next_st;
   lsp_pwr_pat_e pwr_pat;
   lsp_trf_pat_e trf_pat;

   lsp_tim_if tim ();
   assign tim.slow_ph = st.slow_ph;
   assign tim.fast_ph = st.fast_ph;

   logic [NUM_CH-1:0] ch_y;
   logic [NUM_CH-1:0] ch_r;

   // one status tracker per channel, independent
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      lsp_chan_status #(
         .FLASH_CYC (FLASH_CYC)
      ) u_ch (
         .clk_i         (clk_i),
         .sys_rst_i     (sys_rst_i),
         .tim           (tim),
         .msg_evt_i     (msg_evt_i[c]),
         .err_frame_i   (err_frame_i[c]),
         .err_passive_i (err_passive_i[c]),
         .overrun_i     (overrun_i[c]),
         .bus_off_i     (bus_off_i[c]),
         .yellow_o      (ch_y[c]),
         .red_o         (ch_r[c])
      );
   end

   always_comb begin
      next_st = st;
      pwr_pat = LSP_PWR_OFF;
      trf_pat = LSP_TRF_CHAN;

      // shared phase generators, each half period exact
      if (st.slow_cnt == '0) begin
         next_st.slow_cnt = SW'(SLOW_HALF_CYC - 1);
         next_st.slow_ph  = ~st.slow_ph;
      end else begin
         next_st.slow_cnt = st.slow_cnt - 1'b1;
      end
      if (st.fast_cnt == '0) begin
         next_st.fast_cnt = FW'(FAST_HALF_CYC - 1);
         next_st.fast_ph  = ~st.fast_ph;
      end else begin
         next_st.fast_cnt = st.fast_cnt - 1'b1;
      end

      // device-wide states first, per-channel last
      if (host_mode_i) begin
         if (tool_comm_i) begin
            pwr_pat = LSP_PWR_RUN;
            trf_pat = LSP_TRF_RUN;
         end else if (fw_cfg_err_i) begin
            pwr_pat = LSP_PWR_SLOW_WAVE;
            trf_pat = LSP_TRF_SLOW_WAVE;
         end else if (supply_low_i) begin
            pwr_pat = LSP_PWR_SLOW_WAVE;
            trf_pat = LSP_TRF_SLOW_Y;
         end else if (!usb_configured_i) begin
            pwr_pat = LSP_PWR_SLOW_Y;
            trf_pat = LSP_TRF_OFF;
         end else if (disk_busy_i) begin
            pwr_pat = LSP_PWR_GREEN;
            trf_pat = LSP_TRF_FAST_Y;
         end else if (fw_update_i) begin
            pwr_pat = LSP_PWR_GREEN;
            trf_pat = LSP_TRF_FAST_Y;
         end else begin
            pwr_pat = LSP_PWR_GREEN;
         end
      end else begin
         if (hw_err_i) begin
            pwr_pat = LSP_PWR_FAST_WAVE;
            trf_pat = LSP_TRF_FAST_WAVE;
         end else if (battery_fault_i) begin
            pwr_pat = LSP_PWR_FAST_WAVE;
            trf_pat = LSP_TRF_SLOW_WAVE;
         end else if (disk_err_i) begin
            pwr_pat = LSP_PWR_YELLOW;
            trf_pat = LSP_TRF_SLOW_R;
         end else if (cfg_missing_i || prog_load_fail_i) begin
            pwr_pat = LSP_PWR_YELLOW;
            trf_pat = LSP_TRF_FAST_R;
         end else if (log_trig_stop_i) begin
            pwr_pat = LSP_PWR_SLOW_G;
         end else if (log_active_i) begin
            pwr_pat = LSP_PWR_FAST_G;
         end else if (log_armed_i) begin
            pwr_pat = LSP_PWR_GREEN;
         end
      end

      // running restarts at power green each time
      if (pwr_pat != LSP_PWR_RUN) begin
         next_st.run_idx = RW'(`LSP_RUN_FIRST);
      end else if (st.fast_cnt == '0) begin
         if (st.run_idx == RW'(NEL - 1)) begin
            next_st.run_idx = RW'(`LSP_RUN_FIRST);
         end else begin
            next_st.run_idx = st.run_idx + 1'b1;
         end
      end

      case (pwr_pat)
         LSP_PWR_OFF: begin
            next_st.pwr_g = 1'b0;
            next_st.pwr_y = 1'b0;
         end
         LSP_PWR_GREEN: begin
            next_st.pwr_g = 1'b1;
            next_st.pwr_y = 1'b0;
         end
         LSP_PWR_YELLOW: begin
            next_st.pwr_g = 1'b0;
            next_st.pwr_y = 1'b1;
         end
         LSP_PWR_SLOW_G: begin
            next_st.pwr_g = st.slow_ph;
            next_st.pwr_y = 1'b0;
         end
         LSP_PWR_FAST_G: begin
            next_st.pwr_g = st.fast_ph;
            next_st.pwr_y = 1'b0;
         end
         LSP_PWR_SLOW_Y: begin
            next_st.pwr_g = 1'b0;
            next_st.pwr_y = st.slow_ph;
         end
         LSP_PWR_SLOW_WAVE: begin
            next_st.pwr_g = st.slow_ph;
            next_st.pwr_y = ~st.slow_ph;
         end
         LSP_PWR_FAST_WAVE: begin
            next_st.pwr_g = st.fast_ph;
            next_st.pwr_y = ~st.fast_ph;
         end
         LSP_PWR_RUN: begin
            next_st.pwr_g = (st.run_idx == RW'(0));
            next_st.pwr_y = (st.run_idx == RW'(1));
         end
         default: begin
            next_st.pwr_g = 1'b0;
            next_st.pwr_y = 1'b0;
         end
      endcase

      // one pattern for every traffic LED at once
      for (int c = 0; c < NUM_CH; c++) begin
         case (trf_pat)
            LSP_TRF_CHAN: begin
               next_st.trf_y[c] = ch_y[c];
               next_st.trf_r[c] = ch_r[c];
            end
            LSP_TRF_OFF: begin
               next_st.trf_y[c] = 1'b0;
               next_st.trf_r[c] = 1'b0;
            end
            LSP_TRF_SLOW_Y: begin
               next_st.trf_y[c] = st.slow_ph;
               next_st.trf_r[c] = 1'b0;
            end
            LSP_TRF_FAST_Y: begin
               next_st.trf_y[c] = st.fast_ph;
               next_st.trf_r[c] = 1'b0;
            end
            LSP_TRF_SLOW_R: begin
               next_st.trf_y[c] = 1'b0;
               next_st.trf_r[c] = st.slow_ph;
            end
            LSP_TRF_FAST_R: begin
               next_st.trf_y[c] = 1'b0;
               next_st.trf_r[c] = st.fast_ph;
            end
            LSP_TRF_SLOW_WAVE: begin
               next_st.trf_y[c] = st.slow_ph;
               next_st.trf_r[c] = ~st.slow_ph;
            end
            LSP_TRF_FAST_WAVE: begin
               next_st.trf_y[c] = st.fast_ph;
               next_st.trf_r[c] = ~st.fast_ph;
            end
            LSP_TRF_RUN: begin
               next_st.trf_y[c] = (st.run_idx ==
                  RW'(`LSP_CH_ELEMS * c + `LSP_PWR_ELEMS));
               next_st.trf_r[c] = (st.run_idx ==
                  RW'(`LSP_CH_ELEMS * c + `LSP_PWR_ELEMS + 1));
            end
            default: begin
               next_st.trf_y[c] = 1'b0;
               next_st.trf_r[c] = 1'b0;
            end
         endcase
         // a running program owns the indicator it claims
         if (prog_ovr_en_i[c+1]) begin
            next_st.trf_y[c] = trf_ovr_i[2*c];
            next_st.trf_r[c] = trf_ovr_i[2*c+1];
         end
      end
      if (prog_ovr_en_i[0]) begin
         next_st.pwr_g = pwr_ovr_i[0];
         next_st.pwr_y = pwr_ovr_i[1];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pwr_green_o  = st.pwr_g;
   assign pwr_yellow_o = st.pwr_y;
   assign trf_yellow_o = st.trf_y;
   assign trf_red_o    = st.trf_r;

   // helper age counters for the period checks
   logic          h_slow_prev;
   logic          h_fast_prev;
   logic          h_seen_s;
   logic          h_seen_f;
   logic [SW:0]   h_slow_age;
   logic [FW:0]   h_fast_age;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         h_slow_prev <= 1'b0;
         h_fast_prev <= 1'b0;
         h_seen_s    <= 1'b0;
         h_seen_f    <= 1'b0;
         h_slow_age  <= '0;
         h_fast_age  <= '0;
      end else begin
         h_slow_prev <= st.slow_ph;
         h_fast_prev <= st.fast_ph;
         if (st.slow_ph != h_slow_prev) begin
            h_seen_s   <= 1'b1;
            h_slow_age <= (SW+1)'(1);
         end else begin
            h_slow_age <= h_slow_age + 1'b1;
         end
         if (st.fast_ph != h_fast_prev) begin
            h_seen_f   <= 1'b1;
            h_fast_age <= (FW+1)'(1);
         end else begin
            h_fast_age <= h_fast_age + 1'b1;
         end
      end
   end

   property p_slow_half;
      @(posedge clk_i) disable iff (sys_rst_i)
      h_seen_s && st.slow_ph != h_slow_prev |->
         h_slow_age == (SW+1)'(SLOW_HALF_CYC);
   endproperty
   a_slow_half: assert property (p_slow_half)
      else $error("slow half period length wrong");

   property p_fast_half;
      @(posedge clk_i) disable iff (sys_rst_i)
      h_seen_f && st.fast_ph != h_fast_prev |->
         h_fast_age == (FW+1)'(FAST_HALF_CYC);
   endproperty
   a_fast_half: assert property (p_fast_half)
      else $error("fast half period length wrong");

   property p_run_one;
      @(posedge clk_i) disable iff (sys_rst_i)
      pwr_pat == LSP_PWR_RUN && prog_ovr_en_i == '0 |=>
         $onehot({pwr_green_o, pwr_yellow_o, trf_yellow_o, trf_red_o});
   endproperty
   a_run_one: assert property (p_run_one)
      else $error("running pattern lit other than one element");

   property p_host_ok;
      @(posedge clk_i) disable iff (sys_rst_i)
      host_mode_i && usb_configured_i && !tool_comm_i &&
      !fw_cfg_err_i && !supply_low_i && !prog_ovr_en_i[0] |=>
         pwr_green_o && !pwr_yellow_o;
   endproperty
   a_host_ok: assert property (p_host_ok)
      else $error("configured host mode not steady green");

   property p_await_cfg;
      @(posedge clk_i) disable iff (sys_rst_i)
      host_mode_i && !usb_configured_i && !tool_comm_i &&
      !fw_cfg_err_i && !supply_low_i && prog_ovr_en_i == '0 |=>
         !pwr_green_o && pwr_yellow_o == $past(st.slow_ph) &&
         trf_yellow_o == '0 && trf_red_o == '0;
   endproperty
   a_await_cfg: assert property (p_await_cfg)
      else $error("awaiting configuration pattern wrong");

   property p_red_together;
      @(posedge clk_i) disable iff (sys_rst_i)
      (trf_pat == LSP_TRF_FAST_R || trf_pat == LSP_TRF_SLOW_R) &&
      prog_ovr_en_i[NUM_CH:1] == '0 |=>
         (&trf_red_o || trf_red_o == '0) && trf_yellow_o == '0;
   endproperty
   a_red_together: assert property (p_red_together)
      else $error("device error red not shown on all channels");

   property p_load_fail;
      @(posedge clk_i) disable iff (sys_rst_i)
      !host_mode_i && prog_load_fail_i && !hw_err_i &&
      !battery_fault_i && !disk_err_i && prog_ovr_en_i == '0 |=>
         pwr_yellow_o && !pwr_green_o &&
         trf_red_o == {NUM_CH{$past(st.fast_ph)}};
   endproperty
   a_load_fail: assert property (p_load_fail)
      else $error("program load failure pattern wrong");

   property p_fw_update;
      @(posedge clk_i) disable iff (sys_rst_i)
      trf_pat == LSP_TRF_FAST_Y && prog_ovr_en_i[NUM_CH:1] == '0 |=>
         trf_yellow_o == {NUM_CH{$past(st.fast_ph)}} &&
         trf_red_o == '0;
   endproperty
   a_fw_update: assert property (p_fw_update)
      else $error("traffic not fast blink yellow together");

   property p_armed;
      @(posedge clk_i) disable iff (sys_rst_i)
      pwr_pat == LSP_PWR_GREEN && !host_mode_i &&
      !prog_ovr_en_i[0] |=> pwr_green_o ##1 pwr_pat != LSP_PWR_GREEN
         || pwr_green_o;
   endproperty
   a_armed: assert property (p_armed)
      else $error("armed logger power not steady green");

   c_run: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      pwr_pat == LSP_PWR_RUN ##1 trf_red_o[NUM_CH-1]);
   c_hw_err: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      trf_pat == LSP_TRF_FAST_WAVE ##1 &trf_red_o);
   c_update: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      trf_pat == LSP_TRF_FAST_Y ##1 &trf_yellow_o);
   c_overrun: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      overrun_i[0] && host_mode_i ##2 trf_red_o[0]);
endmodule

// ==== test/lsp_led_model.sv ====
`timescale 1ns/10ps
module lsp_led_model #(
   parameter int NUM_CH = 5
) (
   // indicator drives from the encoder
   input  wire logic              pwr_green_i,
   input  wire logic              pwr_yellow_i,
   input  wire logic [NUM_CH-1:0] trf_yellow_i,
   input  wire logic [NUM_CH-1:0] trf_red_i,
   // lit elements in running order, and colour clash
   output logic [2*NUM_CH+1:0]    elem_o,
   output logic                   clash_o
);
   always_comb begin
      elem_o[0] = pwr_green_i;
      elem_o[1] = pwr_yellow_i;
      for (int c = 0; c < NUM_CH; c++) begin
         elem_o[2+2*c] = trf_yellow_i[c];
         elem_o[3+2*c] = trf_red_i[c];
      end
   end
   // one die per colour: both lit at once is no real pattern
   assign clash_o = (|(trf_yellow_i & trf_red_i)) | (pwr_green_i & pwr_yellow_i);
endmodule

// ==== test/led_status_pattern_encoder_test.sv ====
`timescale 1ns/10ps
module led_status_pattern_encoder_test;
   import lsp_pkg::*;
   localparam int NC = 5;
   localparam int FL = 3;
   localparam int SH = 16;
   localparam int FH = 4;
   logic            clk_i = 1'b0;
   logic            sys_rst_i = 1'b1;
   logic [15:0]     st = 16'h0000;
   logic [NC-1:0]   msg = '0, efr = '0, ovr = '0, boff = '0;
   logic [NC:0]     oen = '0;
   logic [1:0]      povr = 2'h0;
   logic [2*NC-1:0] tovr = '0;
   logic            pg, py, clash;
   logic [NC-1:0]   ty, tr;
   logic [2*NC+1:0] elem, pe;
   int              n_errors = 0;
   int              checks_done = 0;
   int              lit, ns;
   // {state word, expected pg py ty tr}: 0 off 1 on 2 slow 3 fast
   logic [23:0] rows [18] = '{24'h000340, 24'h000120, 24'h0007AA,
      24'h000BA8, 24'h00134C, 24'h00434C, 24'h0080FF, 24'h0100FA,
      24'h020012, 24'h040013, 24'h080013, 24'h100040, 24'h2000C0,
      24'h400080, 24'h800343, 24'h900043, 24'h000FAA, 24'h0280FF};

   led_status_pattern_encoder #(.NUM_CH(NC), .FLASH_CYC(FL),
      .SLOW_HALF_CYC(SH), .FAST_HALF_CYC(FH)) DUT (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .host_mode_i(st[0]), .usb_configured_i(st[1]),
      .fw_cfg_err_i(st[2]), .supply_low_i(st[3]), .fw_update_i(st[4]),
      .tool_comm_i(st[5]), .disk_busy_i(st[6]), .hw_err_i(st[7]),
      .battery_fault_i(st[8]), .disk_err_i(st[9]),
      .cfg_missing_i(st[10]), .prog_load_fail_i(st[11]),
      .log_armed_i(st[12]), .log_active_i(st[13]),
      .log_trig_stop_i(st[14]), .msg_evt_i(msg), .err_frame_i(efr),
      .err_passive_i({NC{st[15]}}), .overrun_i(ovr), .bus_off_i(boff),
      .prog_ovr_en_i(oen), .pwr_ovr_i(povr), .trf_ovr_i(tovr),
      .pwr_green_o(pg), .pwr_yellow_o(py),
      .trf_yellow_o(ty), .trf_red_o(tr));

   lsp_led_model #(.NUM_CH(NC)) u_led (
      .pwr_green_i(pg), .pwr_yellow_i(py), .trf_yellow_i(ty),
      .trf_red_i(tr), .elem_o(elem), .clash_o(clash));

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop();
      if (n_errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // one window of a full slow period: on cycles and edges per element
   task automatic run_row(input logic [23:0] r);
      logic [3:0] prev, cur;
      int on [4];
      int tg [4];
      int c;
      @(posedge clk_i) st <= r[23:8];
      repeat (3) @(posedge clk_i);
      @(negedge clk_i) prev = {pg, py, ty[0], tr[0]};
      on = '{0, 0, 0, 0};
      tg = '{0, 0, 0, 0};
      repeat (2*SH) begin
         @(negedge clk_i) cur = {pg, py, ty[0], tr[0]};
         chk("channels alike", 16'h0001, 16'((&ty | ~|ty) & (&tr | ~|tr) & !clash));
         for (int k = 0; k < 4; k++) begin
            on[k] += cur[k];
            tg[k] += cur[k] ^ prev[k];
         end
         prev = cur;
      end
      for (int k = 0; k < 4; k++) begin
         c = r[2*k +: 2];
         chk("on cycles", 16'(c == 0 ? 0 : c == 1 ? 2*SH : SH), 16'(on[k]));
         chk("edges", 16'(c < 2 ? 0 : c == 2 ? 2 : 2*SH/FH), 16'(tg[k]));
      end
   endtask

   // n back-to-back events on one channel, lit cycles counted
   task automatic flash(input logic red, input int n, input int ch);
      int cnt;
      cnt = 0;
      for (int i = 0; i < n + 4*FL; i++) begin
         @(posedge clk_i) begin
            msg[ch] <= !red && i < n;
            efr[ch] <= red && i < n;
         end
         @(negedge clk_i) cnt += red ? tr[ch] : ty[ch];
      end
      chk("flash cycles", 16'(n + FL - 1), 16'(cnt));
   endtask

   initial forever #20 clk_i = ~clk_i;

   initial begin
      repeat (5000) @(posedge clk_i);
      n_errors++;
      report_and_stop();
   end

   initial begin
      repeat (16) @(posedge clk_i);
      @(negedge clk_i) chk("reset outputs", 16'h0000, 16'({pg, py, ty, tr}));
      @(posedge clk_i) sys_rst_i <= 1'b0;
      foreach (rows[i]) run_row(rows[i]);
      @(posedge clk_i) st <= 16'h0003;
      flash(1'b0, 1, 1);
      flash(1'b0, 3, 0);
      flash(1'b1, 2, 2);
      @(posedge clk_i) ovr[3] <= 1'b1;
      @(posedge clk_i) ovr[3] <= 1'b0;
      repeat (2) @(negedge clk_i);
      lit = 0;
      repeat (2*SH) @(negedge clk_i) lit += tr[3];
      chk("overrun held", 16'(2*SH), 16'(lit));
      @(posedge clk_i) boff[3] <= 1'b1;
      @(posedge clk_i) boff[3] <= 1'b0;
      repeat (3) @(negedge clk_i);
      chk("overrun cleared", 16'h0000, 16'(tr[3]));
      @(posedge clk_i) st <= 16'h0023;
      repeat (3) @(negedge clk_i);
      pe = elem;
      ns = 0;
      repeat (2*(2*NC+2)*FH) begin
         @(negedge clk_i);
         chk("one lit", 16'h0001, 16'($onehot(elem)));
         if (elem !== pe) begin
            ns++;
            chk("running step", 16'({pe[2*NC:0], pe[2*NC+1]}), 16'(elem));
         end
         pe = elem;
      end
      chk("running steps", 16'(2*(2*NC+2)), 16'(ns));
      @(posedge clk_i) begin
         oen <= '1;
         povr <= 2'h2;
         tovr <= 10'h249;
      end
      repeat (3) @(negedge clk_i);
      chk("override", 16'h0532, 16'({pg, py, ty, tr}));
      report_and_stop();
   end
endmodule
